// *** design/cls_sequencer.sv ***
// Channel-list sequencer: four-page list RAM, pointer logic, conversion sequencing.
// Assumes single-cycle port access strobes from the bus decoder on sys_clk,
// and an external trigger pin asynchronous to sys_clk.
// The list RAM has no reset; the host must load a page before preloading from it.
//
// Overview of operation
// - Command 022 selected: list port high byte reads the final pointer.
// - Command 043: high-byte write reloads current pointer from start; data ignored.
// - Entry is 8 bits: six channel bits, gain code in bits 7:6.
// - Gain code 00,01,10,11 gives amplifier gain 1,2,4,8.
// - Without the gain option, both gain bits are ignored.
// - Four independent pages; conversion uses only the selected page.
// - Command 005: low-byte write stores entry at pointer, then increments.
// - Write at final pointer returns pointer to start; list overwritten.
// - Command 004: read gives entry low, address high; only a low-byte read then increments.
// - Readback pointer reaching final value resets to start.
// - Command 006: low-byte write preloads multiplexer; data ignored.
// - Command 000 after preload enables pointer logic for conversion.
// - Burst: next conversion starts when previous ends, until count reached.
// - External single mode: each trigger tick starts one conversion.
// - Interrupt mode raises interrupt after each completed conversion.
// - After reset, command 003 and code 002 initialise pointer logic; the code only stores the byte in init_r for readback.
// - Command 053: high-byte write loads start and current pointers.
// - Command 032: high-byte read returns current pointer.
// - Command 063: high-byte write loads final pointer.
`timescale 1ns/10ps
`default_nettype none
`include "cls_consts.svh"
module cls_sequencer
  import cls_pkg::*;
#(
  parameter int PAGES = 4,
  parameter int DEPTH = 256
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] command,
  input wire logic [1:0] page_sel,
  input wire cls_port_access_t port,
  output logic [15:0] port_rdata,
  input wire logic gain_option,
  input wire logic burst_mode,
  input wire logic ext_mode,
  input wire logic intr_enable,
  input wire logic sw_start,
  input wire logic ext_trigger,
  input wire logic [15:0] conv_count,
  input wire logic conv_done,
  output logic conv_start,
  output logic conv_interrupt,
  output cls_mux_sel_t mux_sel,
  output logic logic_enabled,
  output logic [7:0] current_ptr
);
  // List storage, pointers and sequencing state
  logic [7:0] ram_r [PAGES*DEPTH];
  logic [7:0] start_r, final_r, cur_r, init_r;
  logic enabled_r, preloaded_r;
  logic [2:0] trig_sync_r;
  logic trig_seen_r;
  logic [15:0] done_cnt_r;
  cls_conv_state_t state_r;
  cls_mux_sel_t mux_r;
  logic [15:0] rdata_r;
  logic int_r;

  // Decodes the gain code into the amplifier gain, unity without the option
  function automatic logic [3:0] gain_of(input logic [1:0] code, input logic opt);
    if (!opt) return 4'h1;
    case (code)
      2'b00: return 4'h1;
      2'b01: return 4'h2;
      2'b10: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction

  // Next pointer: back to start at final, else plain 8-bit wrap
  function automatic logic [7:0] step(input logic [7:0] p, input logic [7:0] s,
                                      input logic [7:0] f);
    return (p == f) ? s : 8'(p + 8'h01);
  endfunction

  // Splits a list entry into channel and decoded gain for the multiplexer
  function automatic cls_mux_sel_t entry_sel(input logic [7:0] entry, input logic opt);
    return '{channel: entry[`CLS_CHAN_MSB:0],
             gain: gain_of(entry[7:`CLS_GAIN_LSB], opt)};
  endfunction

  // RAM address: selected page above the current pointer
  logic [9:0] addr;
  assign addr = {page_sel, cur_r};

  // Trigger tick on a qualified rising level; list advance on converter done
  logic trig_tick, conv_go, list_adv;
  assign trig_tick = trig_sync_r[2] && trig_sync_r[1] && !trig_seen_r;
  assign list_adv = enabled_r && conv_done;

  // List RAM writes
  always_ff @(posedge sys_clk) begin
    if (port.wr_lo && command == `CLS_CMD_LIST_WRITE)
      ram_r[addr] <= port.wdata;
  end

  // Pointer registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_r <= `CLS_PTR_RESET;
      final_r <= `CLS_PTR_RESET;
      cur_r <= `CLS_PTR_RESET;
      init_r <= `CLS_PTR_RESET;
    end else begin
      if (port.wr_hi) begin
        case (command)
          `CLS_CMD_INIT: init_r <= port.wdata;
          `CLS_CMD_START_WRITE: begin
            start_r <= port.wdata;
            cur_r <= port.wdata;
          end
          `CLS_CMD_FINAL_WRITE: final_r <= port.wdata;
          `CLS_CMD_RESTART: cur_r <= start_r;
          default: ;
        endcase
      end
      // A list step in the same cycle as a high-byte load wins
      if ((port.wr_lo && command == `CLS_CMD_LIST_WRITE) ||
          (port.rd_lo && command == `CLS_CMD_LIST_READ) || list_adv)
        cur_r <= step(cur_r, start_r, final_r);
    end
  end

  // Read data: registered from the selected function
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (port.rd_lo || port.rd_hi) begin
      case (command)
        `CLS_CMD_LIST_READ: rdata_r <= {cur_r, ram_r[addr]};
        `CLS_CMD_FINAL_READ: rdata_r <= {final_r, 8'h00};
        `CLS_CMD_PTR_READ: rdata_r <= {cur_r, 8'h00};
        `CLS_CMD_INIT_READ: rdata_r <= {init_r, 8'h00};
        // Unknown commands read as zero
        default: rdata_r <= 16'h0000;
      endcase
    end
  end

  // Preload and enable sequence
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      preloaded_r <= 1'b0;
      enabled_r <= 1'b0;
      mux_r <= '0;
    end else begin
      if (port.wr_lo && command == `CLS_CMD_PRELOAD) begin
        preloaded_r <= 1'b1;
        mux_r <= entry_sel(ram_r[addr], gain_option);
      end else if (list_adv) begin
        mux_r <= entry_sel(ram_r[addr], gain_option);
      end
      if (command == `CLS_CMD_ENABLE)
        enabled_r <= preloaded_r;
      else
        enabled_r <= 1'b0;
    end
  end

  // Trigger pin synchroniser, three stages; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_sync_r <= 3'b000;
      trig_seen_r <= 1'b0;
    end else begin
      trig_sync_r <= {trig_sync_r[1:0], ext_trigger};
      if (trig_sync_r[2] == trig_sync_r[1])
        trig_seen_r <= trig_sync_r[2]; // Filtered level, idle low like the pin
    end
  end

  // Conversion request: trigger tick in external mode, software start otherwise
  assign conv_go = enabled_r && (ext_mode ? trig_tick : sw_start);

  // Conversion sequencer
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= CLS_IDLE;
      done_cnt_r <= 16'h0000;
      int_r <= 1'b0;
    end else begin
      int_r <= list_adv && intr_enable;
      case (state_r)
        CLS_IDLE: if (conv_go) begin
          state_r <= CLS_RUN;
          done_cnt_r <= 16'h0000;
        end
        CLS_RUN: state_r <= CLS_WAIT;
        CLS_WAIT: if (conv_done) begin
          done_cnt_r <= 16'(done_cnt_r + 16'h0001);
          if (burst_mode && !ext_mode && 16'(done_cnt_r + 16'h0001) < conv_count)
            state_r <= CLS_RUN;
          else
            state_r <= CLS_IDLE;
        end
        default: state_r <= CLS_IDLE;
      endcase
      // Dropping the enable aborts any conversion in flight
      if (!enabled_r) state_r <= CLS_IDLE;
    end
  end

  // Outputs straight from the state and registers
  assign conv_start = (state_r == CLS_RUN);
  assign conv_interrupt = int_r;
  assign mux_sel = mux_r;
  assign logic_enabled = enabled_r;
  assign current_ptr = cur_r;
  assign port_rdata = rdata_r;
endmodule
`default_nettype wire

// *** common/cls_consts.svh ***
// Constants of the channel-list sequencer: command codes, field positions, reset values.
// Included by the package and by the design; definitions only.
`ifndef CLS_CONSTS_SVH
`define CLS_CONSTS_SVH
`define CLS_CMD_ENABLE 8'h00
`define CLS_CMD_INIT 8'h03
`define CLS_CMD_LIST_READ 8'h04
`define CLS_CMD_LIST_WRITE 8'h05
`define CLS_CMD_PRELOAD 8'h06
`define CLS_CMD_INIT_READ 8'h0A
`define CLS_CMD_FINAL_READ 8'h12
`define CLS_CMD_PTR_READ 8'h1A
`define CLS_CMD_RESTART 8'h23
`define CLS_CMD_START_WRITE 8'h2B
`define CLS_CMD_FINAL_WRITE 8'h33
`define CLS_INIT_CODE 8'h02
`define CLS_CHAN_MSB 5
`define CLS_GAIN_LSB 6
`define CLS_PTR_RESET 8'h00
`endif

// *** common/cls_pkg.sv ***
// Types of the channel-list sequencer.
// Assumes cls_consts.svh is on the include path.
`default_nettype none
`include "cls_consts.svh"
package cls_pkg;
  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
    logic rd_lo;
    logic rd_hi;
    logic [7:0] wdata;
  } cls_port_access_t;
  typedef struct packed {
    logic [5:0] channel;
    logic [3:0] gain;
  } cls_mux_sel_t;
  typedef enum logic [2:0] {
    CLS_IDLE = 3'b001,
    CLS_RUN = 3'b010,
    CLS_WAIT = 3'b100
  } cls_conv_state_t;
endpackage
`default_nettype wire

// *** dv/cls_host.sv ***
// Host model: drives the command byte, the page code and the list port strobes.
// Assumes the bench calls its tasks; all changes land on falling edges.
`timescale 1ns/10ps
`default_nettype none
module cls_host
  import cls_pkg::*;
(
  input wire logic sys_clk,
  output logic [7:0] command,
  output logic [1:0] page_sel,
  output cls_port_access_t port,
  input wire logic [15:0] port_rdata
);
  // Idle values at time zero
  initial begin
    command = 8'h00;
    page_sel = 2'h0;
    port = 12'h000;
  end
  // Control byte write: command code and page code
  task automatic go(input logic [7:0] c, input logic [1:0] p);
    @(negedge sys_clk);
    command = c;
    page_sel = p;
  endtask
  // One port access; k picks wr_lo, wr_hi, rd_lo or rd_hi
  task automatic acc(input logic [7:0] c, input int k, input logic [7:0] d,
    output logic [15:0] q);
    go(c, page_sel);
    port = {4'h8 >> k, d};
    @(negedge sys_clk);
    q = port_rdata;
    port = {4'h0, ~d};
  endtask
endmodule
`default_nettype wire

// *** dv/cls_sequencer_asserts.sv ***
// Port checker for the list sequencer, bound into each instance.
// Assumes cls_pkg and cls_consts.svh are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cls_consts.svh"
module cls_sequencer_asserts
  import cls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] command,
  input wire cls_port_access_t port,
  input wire logic [15:0] port_rdata,
  input wire logic gain_option,
  input wire logic intr_enable,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conv_interrupt,
  input wire cls_mux_sel_t mux_sel,
  input wire logic logic_enabled,
  input wire logic [7:0] current_ptr
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Pointer loads and reads through the list port
  a_start_load: assert property (port.wr_hi && command == `CLS_CMD_START_WRITE |=>
    current_ptr == $past(port.wdata)) else $error("start load missed");
  a_ptr_read: assert property (port.rd_hi && command == `CLS_CMD_PTR_READ |=>
    port_rdata == {$past(current_ptr), 8'h00}) else $error("pointer read wrong");
  a_list_addr: assert property (port.rd_lo && command == `CLS_CMD_LIST_READ |=>
    port_rdata[15:8] == $past(current_ptr)) else $error("list read address wrong");
  a_ptr_quiet: assert property (port[11:9] == 3'h0 && !logic_enabled |=>
    $stable(current_ptr)) else $error("pointer moved without access");
  // Multiplexer gain, enable, interrupt and conversion start
  a_gain_code: assert property (logic_enabled |->
    $onehot(mux_sel.gain)) else $error("gain not one of 1 2 4 8");
  a_gain_off: assert property (logic_enabled && !gain_option |->
    mux_sel.gain == 4'h1) else $error("gain bits used without option");
  a_enable_cmd: assert property (logic_enabled |->
    $past(command) == `CLS_CMD_ENABLE) else $error("enabled under other command");
  a_intr_pulse: assert property (conv_done && intr_enable && logic_enabled |=>
    conv_interrupt) else $error("interrupt missing");
  a_start_single: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  c_enabled: cover property ($rose(logic_enabled));
  c_wrap: cover property (port.wr_lo && current_ptr == 8'hFF);
  c_intr: cover property (conv_interrupt);
  c_start: cover property (conv_start);
endmodule
bind cls_sequencer cls_sequencer_asserts chk (.*);
`default_nettype wire

// *** dv/tb.sv ***
// Bench for the list sequencer: pointers, pages, preload, interrupt.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "cls_consts.svh"
module tb;
  import cls_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic gain_option = 1'b0;
  logic intr_enable = 1'b0;
  logic conv_done = 1'b0;
  logic burst_mode = 1'b0;
  logic ext_mode = 1'b0;
  logic sw_start = 1'b0;
  logic ext_trigger = 1'b0;
  logic [15:0] conv_count = 16'h0000;
  logic conv_start;
  logic [7:0] command;
  logic [1:0] page_sel;
  cls_port_access_t port;
  logic [15:0] port_rdata;
  logic conv_interrupt;
  logic logic_enabled;
  cls_mux_sel_t mux_sel;
  logic [7:0] current_ptr;
  logic [15:0] q;
  logic [7:0] e;
  logic [7:0] mem [4][256];
  logic [7:0] st [4];
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 96055;
  always #25 sys_clk = ~sys_clk;
  cls_host hm (.sys_clk(sys_clk), .command(command), .page_sel(page_sel), .port(port),
    .port_rdata(port_rdata));
  cls_sequencer DUT (.sys_clk(sys_clk), .rst_b(rst_b), .command(command),
    .page_sel(page_sel), .port(port), .port_rdata(port_rdata), .gain_option(gain_option),
    .burst_mode(burst_mode), .ext_mode(ext_mode), .intr_enable(intr_enable),
    .sw_start(sw_start), .ext_trigger(ext_trigger), .conv_count(conv_count),
    .conv_done(conv_done), .conv_start(conv_start),
    .conv_interrupt(conv_interrupt), .mux_sel(mux_sel), .logic_enabled(logic_enabled),
    .current_ptr(current_ptr));
  // Expected list address and gain
  function automatic logic [7:0] at(logic [7:0] s, int i);
    return s + 8'(i % 4);
  endfunction
  function automatic logic [3:0] gain_of(logic [1:0] g);
    return gain_option ? 4'h1 << g : 4'h1;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ptrs(input logic [7:0] s, input logic [7:0] f);
    hm.acc(`CLS_CMD_FINAL_WRITE, 1, f, q);
    hm.acc(`CLS_CMD_START_WRITE, 1, s, q);
  endtask
  // Converter model: done one cycle after each start seen; counts starts over 30 cycles
  task automatic conv_run(input logic ext, input logic burst, input int n);
    int starts;
    logic pend;
    starts = 0;
    pend = 1'b0;
    ext_mode = ext;
    burst_mode = burst;
    conv_count = 16'(n);
    sw_start = !ext;
    for (int k = 0; k < 30; k++) begin
      @(negedge sys_clk);
      sw_start = 1'b0;
      ext_trigger = ext && (k % 10 < 5);
      conv_done = pend;
      pend = conv_start;
      starts += int'(conv_start);
    end
    check(16'(starts), 16'(n));
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    rst_b = 1'b1;
    hm.acc(`CLS_CMD_INIT, 1, `CLS_INIT_CODE, q);
    hm.acc(`CLS_CMD_INIT_READ, 3, 8'h00, q);
    check(q, {`CLS_INIT_CODE, 8'h00});
    for (int p = 0; p < 4; p++) begin
      st[p] = (p == 3) ? 8'hFE : 8'($random(seed));
      hm.go(`CLS_CMD_INIT_READ, 2'(p));
      ptrs(st[p], st[p] + 8'h03);
      hm.acc(`CLS_CMD_FINAL_READ, 3, 8'h00, q);
      check(q, {st[p] + 8'h03, 8'h00});
      for (int i = 0; i < 5; i++) begin
        mem[p][at(st[p], i)] = 8'($random(seed));
        hm.acc(`CLS_CMD_LIST_WRITE, 0, mem[p][at(st[p], i)], q);
      end
      hm.acc(`CLS_CMD_PTR_READ, 3, 8'h00, q);
      check(q, {st[p] + 8'h01, 8'h00});
    end
    $display("list write done");
    for (int p = 0; p < 4; p++) begin
      hm.go(`CLS_CMD_INIT_READ, 2'(p));
      ptrs(st[p], st[p] + 8'h03);
      hm.acc(`CLS_CMD_LIST_READ, 2, 8'h00, q);
      hm.acc(`CLS_CMD_RESTART, 1, 8'($random(seed)), q);
      for (int i = 0; i < 5; i++) begin
        hm.acc(`CLS_CMD_LIST_READ, 2, 8'h00, q);
        check(q, {at(st[p], i), mem[p][at(st[p], i)]});
      end
    end
    $display("readback done");
    hm.go(`CLS_CMD_INIT_READ, 2'h0);
    ptrs(8'h00, 8'h00);
    for (int g = 0; g < 5; g++) begin
      e = {(g == 4) ? 2'h3 : 2'(g), 6'($random(seed))};
      hm.acc(`CLS_CMD_LIST_WRITE, 0, e, q);
      gain_option = (g < 4);
      hm.acc(`CLS_CMD_PRELOAD, 0, 8'($random(seed)), q);
      hm.go(`CLS_CMD_ENABLE, 2'h0);
      @(negedge sys_clk);
      check({logic_enabled, 1'b0, mux_sel}, {2'h2, e[5:0], gain_of(e[7:6])});
    end
    $display("preload done");
    intr_enable = 1'b1;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    check(conv_interrupt, 1'b1);
    $display("interrupt done");
    conv_run(1'b0, 1'b0, 1);
    conv_run(1'b0, 1'b1, 3);
    conv_run(1'b1, 1'b0, 3);
    $display("conversion done");
    wrap_up();
  end
  // Watchdog far beyond the few hundred cycles of the sequence
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
